// [verilog/uevs_consts.svh]
/*
  Offsets, fields, resets and timing counts of the event block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef UEVS_CONSTS_SVH
`define UEVS_CONSTS_SVH

`define UEVS_OFS_MASK 8'h00
`define UEVS_OFS_STATUS 8'h04
`define UEVS_OFS_EVCLR 8'h08
`define UEVS_OFS_FIFORST 8'h0c
`define UEVS_OFS_CTRL 8'h10
`define UEVS_CSR_BASE_HI 3'h1

`define UEVS_EV_LSB 8
`define UEVS_EV_MSB 13
`define UEVS_MASK_RESET 32'h00000200
`define UEVS_CTRL_RWAKE 0

`define UEVS_CSR_TRANSMIT_COMPLETE 0
`define UEVS_CSR_BK0 1
`define UEVS_CSR_SETUP 2
`define UEVS_CSR_STALL 3
`define UEVS_CSR_TXRDY 4
`define UEVS_CSR_FHALT 5
`define UEVS_CSR_BK1 6
`define UEVS_CSR_DIR 7
`define UEVS_CSR_TYPE_LSB 8
`define UEVS_CSR_TOGGLE 11
`define UEVS_CSR_ENABLE 15
`define UEVS_CSR_CNT_LSB 16

`define UEVS_IDLE_TIME_US 3000
`define UEVS_CLK_MHZ 40
`define UEVS_IDLE_CYCLES (`UEVS_IDLE_TIME_US * `UEVS_CLK_MHZ)

`endif

// [verilog/uevs_pkg.sv]
/*
  Types of the event block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package uevs_pkg;

    typedef enum logic [1:0] {
        UEVS_WR_IDLE = 2'b01,
        UEVS_WR_RESP = 2'b10
    } uevs_wr_state_type;

    typedef enum logic [1:0] {
        UEVS_RD_IDLE = 2'b01,
        UEVS_RD_DATA = 2'b10
    } uevs_rd_state_type;

endpackage : uevs_pkg

// [verilog/uevs_sync.sv]
/*
  Three-flop synchroniser, last two must agree.
  Assumes an input from another domain.
*/
`timescale 1ns/10ps
module uevs_sync
    import uevs_pkg::*;
(
    input wire logic sys_clk, // Clock
    input wire logic reset, // Async reset
    input wire logic async_in, // Pin level
    output logic level_out // Filtered level
);

    logic meta_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            meta_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end
        else
        begin
            meta_r <= async_in;
            s2_r <= meta_r;
            s3_r <= s2_r;
        end
    end

    // Only the second and third stages vote; first stage may be metastable
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            level_out <= 1'b0;
        else if (s2_r == s3_r)
            level_out <= s3_r;
    end

endmodule : uevs_sync

// [verilog/uevs_endpoint.sv]
/*
  One endpoint's flags, toggle and byte count.
  Assumes same-clock event pulses and masked CSR writes.
*/
`timescale 1ns/10ps
`include "uevs_consts.svh"
module uevs_endpoint
    import uevs_pkg::*;
#(
    parameter int CNT_W = 11
)
(
    input wire logic sys_clk, // Clock
    input wire logic reset, // Async reset
    input wire logic csr_wr, // CSR write strobe
    input wire logic [31:0] csr_wdata, // Write data
    input wire logic [31:0] csr_wmask, // Byte lane mask
    input wire logic fifo_reset, // Endpoint FIFO reset level
    input wire logic tx_ack, // Host acked IN data
    input wire logic bk0_stored, // Packet stored in bank 0
    input wire logic bk1_stored, // Packet stored in bank 1
    input wire logic setup_stored, // Setup packet stored
    input wire logic stall_ack, // Host acked a stall
    input wire logic toggle_flip, // Toggle advance pulse
    input wire logic [CNT_W-1:0] rx_len, // Length of stored packet
    output logic [31:0] csr_rdata, // CSR read value
    output logic ep_irq, // Any source flag set
    output logic out_refuse, // Refuse data OUT
    output logic transmit_packet_ready, // Payload ready to send
    output logic force_halt_handshake, // Stall request pulse
    output logic data_toggle_state, // Current toggle
    output logic endpoint_enable // Endpoint enabled
);

    logic [31:0] clr0;
    logic [31:0] set1;
    logic transmit_complete_r;
    logic receive_bank0_full_r;
    logic receive_bank1_full_r;
    logic setup_received_r;
    logic stall_acknowledged_r;
    logic dir_r;
    logic [2:0] endpoint_type_r;
    logic [CNT_W-1:0] received_byte_count_r;

    assign clr0 = csr_wr ? (csr_wmask & ~csr_wdata) : 32'h00000000;
    assign set1 = csr_wr ? (csr_wmask & csr_wdata) : 32'h00000000;

    // Hardware set beats a firmware clear in the same cycle
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            transmit_complete_r <= 1'b0;
            receive_bank0_full_r <= 1'b0;
            receive_bank1_full_r <= 1'b0;
            setup_received_r <= 1'b0;
            stall_acknowledged_r <= 1'b0;
        end
        else
        begin
            transmit_complete_r <= tx_ack | (transmit_complete_r & ~clr0[`UEVS_CSR_TRANSMIT_COMPLETE]);
            receive_bank0_full_r <= bk0_stored | (receive_bank0_full_r & ~clr0[`UEVS_CSR_BK0]);
            receive_bank1_full_r <= bk1_stored | (receive_bank1_full_r & ~clr0[`UEVS_CSR_BK1]);
            setup_received_r <= setup_stored | (setup_received_r & ~clr0[`UEVS_CSR_SETUP]);
            stall_acknowledged_r <= stall_ack | (stall_acknowledged_r & ~clr0[`UEVS_CSR_STALL]);
        end
    end

    // Firmware set wins over the device clear; firmware must not set while busy
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            transmit_packet_ready <= 1'b0;
        else if (set1[`UEVS_CSR_TXRDY])
            transmit_packet_ready <= 1'b1;
        else if (tx_ack)
            transmit_packet_ready <= 1'b0;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            dir_r <= 1'b0;
            endpoint_type_r <= 3'h0;
            endpoint_enable <= 1'b0;
            force_halt_handshake <= 1'b0;
        end
        else
        begin
            force_halt_handshake <= set1[`UEVS_CSR_FHALT];
            if (csr_wr && csr_wmask[`UEVS_CSR_DIR])
                dir_r <= csr_wdata[`UEVS_CSR_DIR];
            if (csr_wr && csr_wmask[`UEVS_CSR_TYPE_LSB])
                endpoint_type_r <= csr_wdata[`UEVS_CSR_TYPE_LSB +: 3];
            if (csr_wr && csr_wmask[`UEVS_CSR_ENABLE])
                endpoint_enable <= csr_wdata[`UEVS_CSR_ENABLE];
        end
    end

    // FIFO reset holds toggle and count at zero, flags untouched
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            data_toggle_state <= 1'b0;
            received_byte_count_r <= '0;
        end
        else if (fifo_reset)
        begin
            data_toggle_state <= 1'b0;
            received_byte_count_r <= '0;
        end
        else
        begin
            if (toggle_flip)
                data_toggle_state <= ~data_toggle_state;
            if (bk0_stored || bk1_stored)
                received_byte_count_r <= rx_len;
        end
    end

    assign ep_irq = transmit_complete_r | receive_bank0_full_r | receive_bank1_full_r
        | setup_received_r | stall_acknowledged_r;
    assign out_refuse = setup_received_r;

    always_comb
    begin
        csr_rdata = 32'h00000000;
        csr_rdata[`UEVS_CSR_TRANSMIT_COMPLETE] = transmit_complete_r;
        csr_rdata[`UEVS_CSR_BK0] = receive_bank0_full_r;
        csr_rdata[`UEVS_CSR_SETUP] = setup_received_r;
        csr_rdata[`UEVS_CSR_STALL] = stall_acknowledged_r;
        csr_rdata[`UEVS_CSR_TXRDY] = transmit_packet_ready;
        csr_rdata[`UEVS_CSR_BK1] = receive_bank1_full_r;
        csr_rdata[`UEVS_CSR_DIR] = dir_r;
        csr_rdata[`UEVS_CSR_TYPE_LSB +: 3] = endpoint_type_r;
        csr_rdata[`UEVS_CSR_TOGGLE] = data_toggle_state;
        csr_rdata[`UEVS_CSR_ENABLE] = endpoint_enable;
        csr_rdata[`UEVS_CSR_CNT_LSB +: CNT_W] = received_byte_count_r;
    end

endmodule : uevs_endpoint

// [verilog/uevs_top.sv]
/*
  USB device bus event status, event clear, endpoint FIFO reset and
  per-endpoint control/status logic behind an AXI4-Lite slave.
  Assumes same-clock event pulses from the serial interface engine and
  an asynchronous external resume request pin.
*/
`timescale 1ns/10ps
`include "uevs_consts.svh"
module uevs_top
    import uevs_pkg::*;
#(
    parameter int unsigned IDLE_CYCLES = `UEVS_IDLE_CYCLES,
    parameter int NUM_EP = 8,
    parameter int CNT_W = 11
)
(
    input wire logic sys_clk, // 40 MHz clock
    input wire logic reset, // Async reset, high
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic bus_activity, // Bus activity pulse
    input wire logic host_resume_det, // Host resume detected
    input wire logic host_reset_det, // Host reset started
    input wire logic bus_reset_done, // Bus reset finished
    input wire logic sof_det, // SOF token detected
    input wire logic ext_resume_req, // Async external resume pin
    input wire logic [NUM_EP-1:0] ep_tx_ack, // IN data acked
    input wire logic [NUM_EP-1:0] ep_bk0_stored, // Bank 0 stored
    input wire logic [NUM_EP-1:0] ep_bk1_stored, // Bank 1 stored
    input wire logic [NUM_EP-1:0] ep_setup_stored, // Setup stored
    input wire logic [NUM_EP-1:0] ep_stall_ack, // Stall acked
    input wire logic [NUM_EP-1:0] ep_toggle_flip, // Toggle advance
    input wire logic [CNT_W-1:0] rx_len, // Stored packet length
    output logic [NUM_EP-1:0] ep_fifo_reset, // FIFO pointer reset
    output logic [NUM_EP-1:0] ep_out_refuse, // Refuse data OUT
    output logic [NUM_EP-1:0] ep_tx_ready, // Payload ready
    output logic [NUM_EP-1:0] ep_force_halt, // Stall request pulse
    output logic [NUM_EP-1:0] ep_toggle, // Data toggle
    output logic [NUM_EP-1:0] ep_enabled, // Endpoint enabled
    output logic ep0_ready, // Endpoint 0 accepts requests
    output logic suspended, // Suspend mode
    output logic drive_resume, // Resume signalling pulse
    output logic irq // Interrupt request
);

    localparam int IW = $clog2(IDLE_CYCLES + 1);
    localparam int NEV = `UEVS_EV_MSB - `UEVS_EV_LSB + 1;

    uevs_wr_state_type wr_state_r;
    uevs_rd_state_type rd_state_r;
    logic aw_hold_r;
    logic w_hold_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [31:0] w_mask_r;
    logic wr_go;
    logic [31:0] rd_val;
    logic [31:0] mask_r;
    logic [NUM_EP-1:0] ep_rst_r;
    logic remote_wake_enable_r;
    logic [NEV-1:0] ev_r;
    logic [NEV-1:0] ev_set;
    logic [NEV-1:0] ev_clr;
    logic [IW-1:0] idle_cnt_r;
    logic idle_hit;
    logic ext_level;
    logic ext_prev_r;
    logic ext_event;
    logic [31:0] status;
    logic [NUM_EP-1:0] ep_irq;
    logic [31:0] ep_csr [NUM_EP];
    logic [NUM_EP-1:0] ep_wr;

    // Write channel: address and data taken in any order, then committed
    assign s_axi_awready = ~aw_hold_r && (wr_state_r == UEVS_WR_IDLE);
    assign s_axi_wready = ~w_hold_r && (wr_state_r == UEVS_WR_IDLE);
    assign wr_go = aw_hold_r && w_hold_r && (wr_state_r == UEVS_WR_IDLE);
    assign s_axi_bvalid = (wr_state_r == UEVS_WR_RESP);
    assign s_axi_bresp = 2'h0;

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            aw_hold_r <= 1'b0;
            aw_addr_r <= 8'h00;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end
        else if (wr_go)
            aw_hold_r <= 1'b0;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            w_hold_r <= 1'b0;
            w_data_r <= 32'h00000000;
            w_mask_r <= 32'h00000000;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_mask_r <= {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
        end
        else if (wr_go)
            w_hold_r <= 1'b0;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            wr_state_r <= UEVS_WR_IDLE;
        else
        begin
            case (wr_state_r)
                UEVS_WR_IDLE:
                    if (wr_go)
                        wr_state_r <= UEVS_WR_RESP;
                UEVS_WR_RESP:
                    if (s_axi_bready)
                        wr_state_r <= UEVS_WR_IDLE;
                default:
                    wr_state_r <= UEVS_WR_IDLE;
            endcase
        end
    end

    // Software registers; unmapped writes are accepted and dropped
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            mask_r <= `UEVS_MASK_RESET;
            ep_rst_r <= '0;
            remote_wake_enable_r <= 1'b0;
        end
        else if (wr_go)
        begin
            case (aw_addr_r)
                `UEVS_OFS_MASK:
                    mask_r <= (mask_r & ~w_mask_r) | (w_data_r & w_mask_r);
                `UEVS_OFS_FIFORST:
                    ep_rst_r <= (ep_rst_r & ~w_mask_r[NUM_EP-1:0])
                        | (w_data_r[NUM_EP-1:0] & w_mask_r[NUM_EP-1:0]);
                `UEVS_OFS_CTRL:
                    if (w_mask_r[`UEVS_CTRL_RWAKE])
                        remote_wake_enable_r <= w_data_r[`UEVS_CTRL_RWAKE];
                default:
                    remote_wake_enable_r <= remote_wake_enable_r;
            endcase
        end
    end

    assign ev_clr = (wr_go && aw_addr_r == `UEVS_OFS_EVCLR)
        ? (w_data_r[`UEVS_EV_MSB:`UEVS_EV_LSB] & w_mask_r[`UEVS_EV_MSB:`UEVS_EV_LSB])
        : '0;

    // Idle timer; 3 ms without activity puts the port into suspend
    assign idle_hit = ~suspended && (idle_cnt_r == IW'(IDLE_CYCLES - 1)) && ~bus_activity;

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            idle_cnt_r <= '0;
        else if (bus_activity || suspended)
            idle_cnt_r <= '0;
        else if (!idle_hit)
            idle_cnt_r <= idle_cnt_r + IW'(1);
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            suspended <= 1'b0;
        else if (idle_hit)
            suspended <= 1'b1;
        else if (bus_activity || host_resume_det || host_reset_det || drive_resume)
            suspended <= 1'b0;
    end

    uevs_sync u_ext_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .async_in(ext_resume_req),
        .level_out(ext_level)
    );

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            ext_prev_r <= 1'b0;
        else
            ext_prev_r <= ext_level;
    end

    // Edges outside suspend are ignored on purpose
    assign ext_event = ext_level & ~ext_prev_r & suspended;

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            drive_resume <= 1'b0;
        else
            drive_resume <= ext_event & remote_wake_enable_r;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            ep0_ready <= 1'b0;
        else if (bus_reset_done)
            ep0_ready <= 1'b1;
        else if (host_reset_det)
            ep0_ready <= 1'b0;
    end

    assign ev_set = {
        host_resume_det | host_reset_det,
        bus_reset_done,
        sof_det,
        ext_event,
        host_resume_det,
        idle_hit
    };

    // Event set wins over a clear in the same cycle
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            ev_r <= '0;
        else
            ev_r <= ev_set | (ev_r & ~ev_clr);
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_EP; gi++)
        begin : g_ep
            assign ep_wr[gi] = wr_go && (aw_addr_r[7:5] == `UEVS_CSR_BASE_HI)
                && (aw_addr_r[4:2] == 3'(gi)) && (aw_addr_r[1:0] == 2'h0);
            uevs_endpoint #(
                .CNT_W(CNT_W)
            ) u_ep (
                .sys_clk(sys_clk),
                .reset(reset),
                .csr_wr(ep_wr[gi]),
                .csr_wdata(w_data_r),
                .csr_wmask(w_mask_r),
                .fifo_reset(ep_rst_r[gi]),
                .tx_ack(ep_tx_ack[gi]),
                .bk0_stored(ep_bk0_stored[gi]),
                .bk1_stored(ep_bk1_stored[gi]),
                .setup_stored(ep_setup_stored[gi]),
                .stall_ack(ep_stall_ack[gi]),
                .toggle_flip(ep_toggle_flip[gi]),
                .rx_len(rx_len),
                .csr_rdata(ep_csr[gi]),
                .ep_irq(ep_irq[gi]),
                .out_refuse(ep_out_refuse[gi]),
                .transmit_packet_ready(ep_tx_ready[gi]),
                .force_halt_handshake(ep_force_halt[gi]),
                .data_toggle_state(ep_toggle[gi]),
                .endpoint_enable(ep_enabled[gi])
            );
        end
    endgenerate

    assign ep_fifo_reset = ep_rst_r;

    always_comb
    begin
        status = 32'h00000000;
        status[NUM_EP-1:0] = ep_irq;
        status[`UEVS_EV_MSB:`UEVS_EV_LSB] = ev_r;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            irq <= 1'b0;
        else
            irq <= |(status & mask_r);
    end

    // Read decode; unmapped and write-only addresses read as zero
    always_comb
    begin
        rd_val = 32'h00000000;
        if (s_axi_araddr[7:5] == `UEVS_CSR_BASE_HI && s_axi_araddr[1:0] == 2'h0)
            rd_val = ep_csr[s_axi_araddr[4:2]];
        else
        begin
            case (s_axi_araddr)
                `UEVS_OFS_MASK: rd_val = mask_r;
                `UEVS_OFS_STATUS: rd_val = status;
                `UEVS_OFS_FIFORST: rd_val[NUM_EP-1:0] = ep_rst_r;
                `UEVS_OFS_CTRL: rd_val[`UEVS_CTRL_RWAKE] = remote_wake_enable_r;
                default: rd_val = 32'h00000000;
            endcase
        end
    end

    assign s_axi_arready = (rd_state_r == UEVS_RD_IDLE);
    assign s_axi_rvalid = (rd_state_r == UEVS_RD_DATA);
    assign s_axi_rresp = 2'h0;

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            rd_state_r <= UEVS_RD_IDLE;
            s_axi_rdata <= 32'h00000000;
        end
        else
        begin
            case (rd_state_r)
                UEVS_RD_IDLE:
                    if (s_axi_arvalid)
                    begin
                        s_axi_rdata <= rd_val;
                        rd_state_r <= UEVS_RD_DATA;
                    end
                UEVS_RD_DATA:
                    if (s_axi_rready)
                        rd_state_r <= UEVS_RD_IDLE;
                default:
                    rd_state_r <= UEVS_RD_IDLE;
            endcase
        end
    end

endmodule : uevs_top

// [tb/uevs_host_model.sv]
/*
  Host side: one-cycle event pulses.
  Assumes send is called on sys_clk.
*/
`timescale 1ns/10ps
module uevs_host_model
(
    input wire logic sys_clk, // Clock
    output logic bus_activity, // Traffic seen
    output logic host_resume_det, // Resume signalling
    output logic host_reset_det, // Reset start
    output logic bus_reset_done, // Reset end
    output logic sof_det, // Frame token
    output logic [7:0] ep_tx_ack, // IN acked
    output logic [7:0] ep_setup_stored, // Setup stored
    output logic [7:0] ep_toggle_flip, // Toggle advance
    output logic [7:0] ep_bk0_stored // Bank 0 stored
);
    initial {bus_activity, host_resume_det, host_reset_det, bus_reset_done, sof_det} = '0;
    initial {ep_tx_ack, ep_setup_stored, ep_toggle_flip, ep_bk0_stored} = '0;

    task send(input int k, input logic [7:0] m);
        @(posedge sys_clk);
        case (k)
            0: bus_activity <= 1'b1;
            1: host_resume_det <= 1'b1;
            2: host_reset_det <= 1'b1;
            3: bus_reset_done <= 1'b1;
            4: sof_det <= 1'b1;
            5: ep_tx_ack <= m;
            6: ep_setup_stored <= m;
            7: ep_toggle_flip <= m;
            default: ep_bk0_stored <= m;
        endcase
        @(posedge sys_clk);
        {bus_activity, host_resume_det, host_reset_det, bus_reset_done, sof_det} <= '0;
        {ep_tx_ack, ep_setup_stored, ep_toggle_flip, ep_bk0_stored} <= '0;
    endtask : send
endmodule : uevs_host_model

// [tb/uevs_properties.sv]
/*
  Port checker of uevs_top.
  Assumes binding by port name.
*/
`timescale 1ns/10ps
module uevs_properties
#(
    parameter int NUM_EP = 8
)
(
    input wire logic sys_clk, // Clock
    input wire logic reset, // Async reset
    input wire logic s_axi_bvalid, // Write resp
    input wire logic s_axi_bready, // Resp taken
    input wire logic s_axi_rvalid, // Read valid
    input wire logic s_axi_rready, // Read taken
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic bus_activity, // Traffic
    input wire logic bus_reset_done, // Reset end
    input wire logic host_reset_det, // Reset start
    input wire logic [NUM_EP-1:0] ep_setup_stored, // Setup
    input wire logic [NUM_EP-1:0] ep_tx_ack, // IN acked
    input wire logic [NUM_EP-1:0] ep_out_refuse, // Refuse OUT
    input wire logic [NUM_EP-1:0] ep_tx_ready, // Payload ready
    input wire logic [NUM_EP-1:0] ep_fifo_reset, // FIFO reset
    input wire logic [NUM_EP-1:0] ep_toggle, // Toggle
    input wire logic ep0_ready, // Endpoint 0 ready
    input wire logic suspended, // Suspend
    input wire logic drive_resume // Resume pulse
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata moved");
    a_idle_hold: assert property (bus_activity |=> !suspended [*8])
        else $error("early suspend");
    a_reset_end: assert property (bus_reset_done && !host_reset_det |=> ep0_ready)
        else $error("ep0 not ready");
    a_fifo_toggle: assert property ((ep_toggle & $past(ep_fifo_reset)) == '0)
        else $error("toggle not cleared");
    a_setup_refuse: assert property ((ep_out_refuse & $past(ep_setup_stored)) == $past(ep_setup_stored))
        else $error("no refuse on setup");
    a_refuse_cause: assert property ((ep_out_refuse & ~$past(ep_out_refuse) & ~$past(ep_setup_stored)) == '0)
        else $error("refuse without setup");
    a_ready_clear: assert property (($past(ep_tx_ready) & ~ep_tx_ready & ~$past(ep_tx_ack)) == '0)
        else $error("ready fell early");
    a_resume_pulse: assert property (drive_resume |=> !drive_resume && !suspended)
        else $error("bad resume pulse");
    a_resume_cause: assert property ($rose(drive_resume) |-> $past(suspended))
        else $error("resume while awake");

    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_resume: cover property (drive_resume);
    c_fifo_reset: cover property (|ep_fifo_reset);
endmodule : uevs_properties

bind uevs_top uevs_properties #(.NUM_EP(NUM_EP)) chk (.*);

// [tb/tb.sv]
/*
  Bench: AXI4-Lite master and scenarios.
  Assumes uevs_top, host model, checker.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
    $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb;
    logic sys_clk, reset, ext_resume_req;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic bus_activity, host_resume_det, host_reset_det, bus_reset_done, sof_det;
    logic [7:0] ep_tx_ack, ep_bk0_stored, ep_bk1_stored, ep_setup_stored, ep_stall_ack;
    logic [7:0] ep_toggle_flip, ep_fifo_reset, ep_out_refuse, ep_tx_ready, ep_force_halt;
    logic [7:0] ep_toggle, ep_enabled;
    logic [10:0] rx_len;
    logic ep0_ready, suspended, drive_resume, irq;
    int num_errors = 0;
    int compares = 0;
    assign ep_bk1_stored = '0;
    assign ep_stall_ack = '0;
    assign rx_len = 11'h005;

    uevs_top #(.IDLE_CYCLES(20)) uut (.*);
    uevs_host_model host (.*);

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task tally_and_finish;
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    task hang;
        num_errors++;
        tally_and_finish;
    endtask : hang

    task look;
        @(negedge sys_clk);
    endtask : look

    // Readies sampled mid-cycle, released at the handshake edge
    task wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        logic pa, pw, pb;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        pb = 1'b0;
        for (n = 0; n < 99 && !pb; n++)
        begin
            @(negedge sys_clk);
            {pa, pw, pb} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
            @(posedge sys_clk);
            s_axi_awvalid <= s_axi_awvalid & ~pa;
            s_axi_wvalid <= s_axi_wvalid & ~pw;
            s_axi_bready <= ~pb;
        end
        if (!pb) hang;
    endtask : wr

    task rd(input logic [7:0] a);
        int n;
        logic pa, pr;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        pr = 1'b0;
        for (n = 0; n < 99 && !pr; n++)
        begin
            @(negedge sys_clk);
            {pa, pr, d} = {s_axi_arready, s_axi_rvalid, s_axi_rdata};
            @(posedge sys_clk);
            s_axi_arvalid <= s_axi_arvalid & ~pa;
            s_axi_rready <= ~pr;
        end
        if (!pr) hang;
    endtask : rd

    task t_suspend;
        int n;
        rd(8'h00);
        `CHK(d, 32'h0000_0200)
        host.send(0, 8'h00);
        repeat (15) @(posedge sys_clk);
        look;
        `CHK(suspended, 1'b0)
        repeat (10) @(posedge sys_clk);
        look;
        `CHK(suspended, 1'b1)
        wr(8'h10, 32'h0000_0001);
        ext_resume_req <= 1'b1;
        for (n = 0; n < 30 && drive_resume !== 1'b1; n++) @(negedge sys_clk);
        `CHK(drive_resume, 1'b1)
        rd(8'h04);
        `CHK({d[10], d[8], suspended}, 3'b110)
    endtask : t_suspend

    task t_events;
        wr(8'h08, 32'h0000_3f00);
        for (int k = 1; k < 5; k++) host.send(k, 8'h00);
        rd(8'h04);
        `CHK(d & 32'h0000_3e00, 32'h0000_3a00)
        `CHK({ep0_ready, irq}, 2'b11)
        wr(8'h08, 32'h0000_0a00);
        rd(8'h04);
        `CHK(d & 32'h0000_3e00, 32'h0000_3000)
        wr(8'h08, 32'h0000_3000);
        rd(8'h04);
        `CHK({d[13:9], irq}, 6'h00)
    endtask : t_events

    task t_endpoint;
        wr(8'h00, 32'h0000_0004);
        host.send(6, 8'h04);
        look;
        `CHK(ep_out_refuse, 8'h04)
        rd(8'h04);
        `CHK({d[7:0], irq}, 9'h009)
        wr(8'h28, 32'h0000_0000);
        rd(8'h04);
        `CHK({ep_out_refuse[2], d[2]}, 2'b00)
        wr(8'h28, 32'h0000_0010);
        `CHK(ep_tx_ready, 8'h04)
        host.send(5, 8'h04);
        look;
        `CHK(ep_tx_ready, 8'h00)
        wr(8'h28, 32'h0000_0001);
        rd(8'h28);
        `CHK(d[4:0], 5'h01)
        wr(8'h28, 32'h0000_0000);
        host.send(7, 8'h04);
        host.send(8, 8'h04);
        rd(8'h28);
        `CHK({d[26:16], d[11], d[1], d[0]}, 14'h002e)
        wr(8'h0c, 32'h0000_0004);
        rd(8'h28);
        `CHK({d[26:16], d[11], d[1], ep_fifo_reset}, 21'h000104)
        wr(8'h0c, 32'h0000_0000);
        wr(8'h28, 32'h0000_0000);
        rd(8'h04);
        `CHK(d[7:0], 8'h00)
        rd(8'h40);
        `CHK(d, 32'h0000_0000)
    endtask : t_endpoint

    initial
    begin
        reset = 1'b1;
        ext_resume_req = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        t_suspend;
        t_events;
        t_endpoint;
        tally_and_finish;
    end
endmodule : tb
